// File: asc_pkg.sv
// asc_pkg: register map, field layout, reset values, timing and carriers
// for the converter sequencing control block.
// assumes a 32-bit APB slave with registers one per aligned word.
package asc_pkg;

   // -----------------------------------------------------------------
   // register indices; byte address is four times the index
   // -----------------------------------------------------------------
   localparam logic [11:0] CTRL_IDX   = 12'h3D6;
   localparam logic [11:0] CFG_IDX    = 12'h3D7;
   localparam logic [11:0] THIRD_IDX  = 12'h3D4;
   localparam logic [11:0] RESULT_IDX = 12'h3C0;   // eight words upward

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int CTRL_CH_LSB  = 0;
   localparam int CTRL_MODE    = 3;
   localparam int CTRL_TRG     = 5;
   localparam int CTRL_START   = 6;
   localparam int CTRL_CLOCK_DIV_SEL_LOW    = 7;
   localparam int CFG_RES      = 3;
   localparam int CFG_CLOCK_DIV_SEL_HIGH     = 4;
   localparam int CFG_REF      = 5;
   localparam int CFG_EXT_LSB  = 6;
   localparam int THIRD_SH     = 0;
   localparam int THIRD_GRP_LSB = 1;

   // -----------------------------------------------------------------
   // encodings and timing in pclk cycles
   // -----------------------------------------------------------------
   localparam logic [1:0] EXT_NONE = 2'h0;
   localparam logic [1:0] EXT_IN0  = 2'h1;
   localparam logic [1:0] EXT_IN1  = 2'h2;
   localparam logic [1:0] EXT_BAD  = 2'h3;
   localparam logic [5:0] CYC_SH_8   = 6'h1C;   // 28 cycles
   localparam logic [5:0] CYC_SH_10  = 6'h21;   // 33 cycles
   localparam logic [5:0] CYC_NSH_8  = 6'h31;   // 49 cycles
   localparam logic [5:0] CYC_NSH_10 = 6'h3B;   // 59 cycles

   // -----------------------------------------------------------------
   // register layouts, reset values and carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic       clock_div_sel_low;
      logic       start;
      logic       trigger_source_sel;
      logic       mode;
      logic [2:0] channel;
   } asc_ctrl_s;

   typedef struct packed {
      logic [1:0] ext;
      logic       ref_connect;
      logic       clock_div_sel_high;
      logic       res10;
   } asc_cfg_s;

   typedef struct packed {
      logic [1:0] group;
      logic       sh;
   } asc_third_s;

   localparam asc_ctrl_s  CTRL_RST  = '{default: 1'b0};
   localparam asc_cfg_s   CFG_RST   = '{default: 1'b0};
   localparam asc_third_s THIRD_RST = '{default: 1'b0};

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } asc_apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } asc_apb_rsp_s;

   typedef struct packed {
      logic [1:0] group;
      logic [2:0] channel;
      logic [1:0] ext;
   } asc_sel_s;

endpackage

// File: asc_conv_timer.sv
// asc_conv_timer: counts the cycles of one conversion and flags its end.
// assumes start is a one-cycle pulse and len is steady while it is high.
module asc_conv_timer (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // control
   input  wire logic       start,
   input  wire logic       abort,
   input  wire logic [5:0] len,
   // status
   output logic            done,
   output logic            busy
);
   import asc_pkg::*;

   typedef struct packed {
      logic       busy;
      logic [5:0] cnt;
   } asc_tmr_s;

   asc_tmr_s st;
   asc_tmr_s next_st;

   // last busy cycle ends the conversion
   assign done = st.busy && (st.cnt == 6'h00);
   assign busy = st.busy;

   // load on start, count down, stop on abort or end
   always_comb begin
      next_st = st;
      if (abort || done) begin
         next_st.busy = 1'b0;
      end else if (st.busy) begin
         next_st.cnt = st.cnt - 6'h01;
      end
      if (start && !abort) begin
         next_st.busy = 1'b1;
         next_st.cnt  = len - 6'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   a_len_eight_bit: assert property (@(posedge pclk)
      disable iff (!presetn || abort)
      (start && len == 6'h1C) |-> ##28 done)
      else $error("8-bit sample-hold conversion not 28 cycles");
   a_len_ten_bit: assert property (@(posedge pclk)
      disable iff (!presetn || abort)
      (start && len == 6'h21) |-> (!done) [*8] ##26 done)
      else $error("10-bit sample-hold conversion not 33 cycles");

endmodule

// File: asc_top.sv
// asc_top: converter sequencing control with APB register access.
// assumes an analog core that samples the selected input while busy and
// presents a right-justified code on conv_code in the done cycle.
//
// Decided for this implementation: the APB slave port.
module asc_top (
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // register bus
   input  wire asc_pkg::asc_apb_req_s apb_req,
   output asc_pkg::asc_apb_rsp_s      apb_rsp,
   // trigger pin and analog core
   input  wire logic                  external_trigger_pin,
   input  wire logic [9:0]            conv_code,
   output asc_pkg::asc_sel_s          analog_sel,
   output logic                       reference_connect,
   output logic                       sample_hold_on,
   output logic                       convert_busy,
   output logic                       conv_start,
   // event
   output logic                       conv_irq
);
   import asc_pkg::*;

   typedef enum logic [2:0] {
      PH_IDLE  = 3'b001,
      PH_ARMED = 3'b010,
      PH_CONV  = 3'b100
   } asc_phase_e;

   typedef struct packed {
      asc_ctrl_s        ctrl;
      asc_cfg_s         cfg;
      asc_third_s       third;
      asc_phase_e       phase;
      logic [7:0][9:0]  result;
      logic [2:0]       res_idx;
      logic             res10;
      logic             trig_prev;
      logic             conv_start;
      logic             irq;
      asc_apb_rsp_s     rsp;
   } asc_state_s;

   asc_state_s st;
   asc_state_s next_st;

   logic tmr_done;
   logic tmr_busy;
   logic abort;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------

   // address decode shared by reads and writes: 0-7 results, 8 ctrl,
   // 9 cfg, 10 third, 15 unmapped
   function automatic logic [3:0] reg_decode(input logic [11:0] addr);
      logic [3:0] sel;
      sel = 4'hF;
      if (addr[1:0] == 2'h0) begin
         if (addr[11:2] == CTRL_IDX[9:0]) begin
            sel = 4'h8;
         end else if (addr[11:2] == CFG_IDX[9:0]) begin
            sel = 4'h9;
         end else if (addr[11:2] == THIRD_IDX[9:0]) begin
            sel = 4'hA;
         end else if (addr[11:5] == RESULT_IDX[9:3]) begin
            sel = {1'b0, addr[4:2]};
         end
      end
      return sel;
   endfunction

   // conversion length from sample-hold choice and resolution
   function automatic logic [5:0] conv_len(input logic sh,
                                           input logic res10);
      logic [5:0] n;
      if (sh) begin
         n = res10 ? CYC_SH_10 : CYC_SH_8;
      end else begin
         n = res10 ? CYC_NSH_10 : CYC_NSH_8;
      end
      return n;
   endfunction

   // result register that belongs to the selected input
   function automatic logic [2:0] result_slot(input logic [1:0] ext,
                                              input logic [2:0] ch);
      logic [2:0] slot;
      unique case (ext)
         EXT_IN0: slot = 3'h0;
         EXT_IN1: slot = 3'h1;
         default: slot = ch;
      endcase
      return slot;
   endfunction

   // -----------------------------------------------------------------
   // conversion timer
   // -----------------------------------------------------------------
   asc_conv_timer u_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (st.conv_start),
      .abort   (abort),
      .len     (conv_len(st.third.sh, st.cfg.res10)),
      .done    (tmr_done),
      .busy    (tmr_busy)
   );

   // -----------------------------------------------------------------
   // next-state logic
   // -----------------------------------------------------------------
   logic [3:0]  wsel;
   logic [3:0]  rsel;
   logic        wr_acc;
   logic        trig_fall;
   logic        start_was;
   logic [31:0] rword;

   // bus decode sits outside the next-state process, so abort never
   // reads a value that process is still working out
   assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite
                   && st.rsp.pready;
   assign wsel   = reg_decode(apb_req.paddr);

   // a stop written in the same cycle as the timer's end wins, so a halted
   // conversion never deposits a result
   assign abort = wr_acc && (wsel == 4'h8) && !apb_req.pwdata[CTRL_START];

   always_comb begin
      next_st            = st;
      next_st.conv_start = 1'b0;
      next_st.irq        = 1'b0;
      rsel      = wsel;
      rword     = 32'h0000_0000;
      trig_fall = st.trig_prev && !external_trigger_pin;
      start_was = 1'b0;
      next_st.trig_prev = external_trigger_pin;

      // end of one conversion: store and decide what follows
      if (tmr_done && st.phase == PH_CONV && !abort) begin
         next_st.result[st.res_idx] = st.res10 ? conv_code
                                    : {2'h0, conv_code[7:0]};
         if (st.ctrl.mode) begin
            next_st.conv_start = 1'b1;
         end else begin
            next_st.irq   = 1'b1;
            next_st.phase = PH_IDLE;
            if (!st.ctrl.trigger_source_sel) begin
               next_st.ctrl.start = 1'b0;
            end
         end
      end

      // external trigger: only a falling edge seen while armed counts
      if (st.phase == PH_ARMED && trig_fall) begin
         next_st.phase      = PH_CONV;
         next_st.conv_start = 1'b1;
      end

      // register writes land after hardware updates so a set wins
      start_was = next_st.ctrl.start;
      if (wr_acc) begin
         unique case (wsel)
            4'h8: begin
               next_st.ctrl.channel = apb_req.pwdata[CTRL_CH_LSB +: 3];
               next_st.ctrl.mode    = apb_req.pwdata[CTRL_MODE];
               next_st.ctrl.trigger_source_sel     = apb_req.pwdata[CTRL_TRG];
               next_st.ctrl.clock_div_sel_low    = apb_req.pwdata[CTRL_CLOCK_DIV_SEL_LOW];
               // start refused while the ladder has no reference
               next_st.ctrl.start   = apb_req.pwdata[CTRL_START]
                                      && st.cfg.ref_connect;
               if (!apb_req.pwdata[CTRL_START]) begin
                  next_st.phase = PH_IDLE;
                  // a trigger edge in the stop cycle must not launch
                  next_st.conv_start = 1'b0;
               end else if (!start_was && st.cfg.ref_connect) begin
                  if (apb_req.pwdata[CTRL_TRG]) begin
                     next_st.phase = PH_ARMED;
                  end else begin
                     next_st.phase      = PH_CONV;
                     next_st.conv_start = 1'b1;
                  end
               end
            end
            4'h9: begin
               next_st.cfg.res10 = apb_req.pwdata[CFG_RES];
               next_st.cfg.clock_div_sel_high  = apb_req.pwdata[CFG_CLOCK_DIV_SEL_HIGH];
               // disconnect is held off while a conversion runs
               if (apb_req.pwdata[CFG_REF] || st.phase == PH_IDLE) begin
                  next_st.cfg.ref_connect = apb_req.pwdata[CFG_REF];
               end
               // forbidden code falls back to no extended input
               if (apb_req.pwdata[CFG_EXT_LSB +: 2] != EXT_BAD) begin
                  next_st.cfg.ext = apb_req.pwdata[CFG_EXT_LSB +: 2];
               end else begin
                  next_st.cfg.ext = EXT_NONE;
               end
            end
            4'hA: begin
               next_st.third.sh    = apb_req.pwdata[THIRD_SH];
               next_st.third.group = apb_req.pwdata[THIRD_GRP_LSB +: 2];
            end
            default: begin
               // results are read-only, unmapped writes are dropped
            end
         endcase
      end

      // capture where this conversion's result goes and its width
      if (next_st.conv_start) begin
         next_st.res_idx = result_slot(next_st.cfg.ext,
                                       next_st.ctrl.channel);
         next_st.res10   = next_st.cfg.res10;
      end

      // read data: unassigned bits read as zero
      unique case (rsel)
         4'h8: rword = {24'h00_0000, st.ctrl.clock_div_sel_low, st.ctrl.start,
                        st.ctrl.trigger_source_sel, 1'b0, st.ctrl.mode,
                        st.ctrl.channel};
         4'h9: rword = {24'h00_0000, st.cfg.ext, st.cfg.ref_connect,
                        st.cfg.clock_div_sel_high, st.cfg.res10, 3'h0};
         4'hA: rword = {29'h0000_0000, st.third.group, st.third.sh};
         4'hF: rword = 32'h0000_0000;
         default: rword = {22'h00_0000, st.result[rsel[2:0]]};
      endcase

      // zero-wait slave: data is prepared in setup, ready in access
      next_st.rsp.pready  = apb_req.psel && !apb_req.penable;
      next_st.rsp.pslverr = apb_req.psel && !apb_req.penable
                            && (rsel == 4'hF);
      if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
         next_st.rsp.prdata = rword;
      end
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st            <= '0;
         st.ctrl       <= CTRL_RST;
         st.cfg        <= CFG_RST;
         st.third      <= THIRD_RST;
         st.phase      <= PH_IDLE;
         st.trig_prev  <= 1'b1;   // no false edge just after reset
      end else begin
         st <= next_st;
      end
   end

   // -----------------------------------------------------------------
   // outputs, all but convert_busy straight from state flops
   // -----------------------------------------------------------------
   assign apb_rsp            = st.rsp;
   assign analog_sel.channel = st.ctrl.channel;
   assign analog_sel.group   = st.third.group;
   assign analog_sel.ext     = st.cfg.ext;
   assign reference_connect  = st.cfg.ref_connect;
   assign sample_hold_on     = st.third.sh;
   assign convert_busy       = (st.phase == PH_CONV);
   assign conv_start         = st.conv_start;
   assign conv_irq           = st.irq;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_conv_end;
      tmr_done && st.phase == PH_CONV && !abort;
   endsequence

   sequence s_sw_start;
      wr_acc && wsel == 4'h8 && apb_req.pwdata[CTRL_START]
      && !apb_req.pwdata[CTRL_TRG] && st.cfg.ref_connect
      && st.phase == PH_IDLE && !st.ctrl.start;
   endsequence

   a_oneshot_irq: assert property (
      (s_conv_end and !st.ctrl.mode) |=> conv_irq)
      else $error("one-shot end gave no interrupt");
   a_repeat_no_irq: assert property (
      st.ctrl.mode && $past(st.ctrl.mode) |-> !conv_irq)
      else $error("interrupt raised in repeat mode");
   a_repeat_restart: assert property (
      (s_conv_end and st.ctrl.mode) |=> conv_start && convert_busy)
      else $error("repeat mode did not restart");
   a_start_cleared: assert property (
      (s_conv_end and !st.ctrl.mode && !st.ctrl.trigger_source_sel && !wr_acc)
      |=> !st.ctrl.start && !convert_busy)
      else $error("start flag not cleared after one-shot");
   a_sw_start_go: assert property (
      s_sw_start |=> conv_start ##1 tmr_busy)
      else $error("software start did not begin conversion");
   a_stop_halts: assert property (
      abort |=> !convert_busy ##1 !tmr_busy)
      else $error("stop write did not halt conversion");
   a_ext_armed_only: assert property (
      (st.phase == PH_ARMED && !trig_fall && !wr_acc) |=> !conv_start)
      else $error("external start without falling edge");
   a_ext_fall_go: assert property (
      (st.phase == PH_ARMED && trig_fall && !abort) |=> conv_start)
      else $error("falling trigger edge missed");
   a_ref_held: assert property (
      convert_busy |-> reference_connect)
      else $error("reference cut during conversion");
   a_result_8bit: assert property (
      (s_conv_end and !st.res10)
      |=> st.result[$past(st.res_idx)][9:8] == 2'h0)
      else $error("8-bit result wider than 8 bits");
   a_ext_legal: assert property (
      analog_sel.ext != EXT_BAD)
      else $error("forbidden extended input code held");
   a_oneshot_idle: assert property (
      (s_conv_end and !st.ctrl.mode && !wr_acc)
      |=> !convert_busy && !conv_start)
      else $error("one-shot did not stop after one conversion");
   a_result_ten_bit: assert property (
      (s_conv_end and st.res10)
      |=> st.result[$past(st.res_idx)] == $past(conv_code))
      else $error("10-bit result not stored in full");
   a_ext_slot_zero: assert property (
      (conv_start && analog_sel.ext == EXT_IN0) |-> st.res_idx == 3'h0)
      else $error("extended input 0 result not aimed at slot 0");
   a_ext_slot_one: assert property (
      (conv_start && analog_sel.ext == EXT_IN1) |-> st.res_idx == 3'h1)
      else $error("extended input 1 result not aimed at slot 1");
   a_chan_slot: assert property (
      (conv_start && analog_sel.ext == EXT_NONE)
      |-> st.res_idx == analog_sel.channel)
      else $error("result not aimed at the selected input");
   a_bad_ext_drop: assert property (
      (wr_acc && wsel == 4'h9
       && apb_req.pwdata[CFG_EXT_LSB +: 2] == EXT_BAD)
      |=> analog_sel.ext == EXT_NONE)
      else $error("forbidden extended code not replaced");
   a_no_ref_no_go: assert property (
      (wr_acc && wsel == 4'h8 && !st.cfg.ref_connect) |=> !st.ctrl.start)
      else $error("start accepted without reference");

endmodule

// File: asc_far_model.sv
// asc_far_model: stand-in for the trigger pin and the analog core.
// assumes busy covers the conversion; code is only trusted around done.
module asc_far_model (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // bench requests and block status
   input  wire logic       fall_req,
   input  wire logic       busy,
   input  wire logic [9:0] code,
   // far side pins
   output logic            external_trigger_pin,
   output logic [9:0]      conv_code
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] low_cnt;
   logic       busy_d;
   logic [9:0] junk;
   // pin rests high; a request pulls it low for two edges
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_cnt <= 2'h0;
         busy_d <= 1'b0;
         junk <= 10'h2A5;
      end else begin
         low_cnt <= fall_req ? 2'h2 : (low_cnt == 2'h0 ? 2'h0 : low_cnt - 1);
         busy_d <= busy;
         junk <= ~junk;
      end
   end
   assign external_trigger_pin = (low_cnt == 2'h0);
   // churning pattern outside a conversion, so a stale sample shows
   assign conv_code = (busy | busy_d) ? code : junk;
endmodule

// File: adc_sequencing_control_tb_top.sv
// adc_sequencing_control_tb_top: self-checking bench for asc_top.
// assumes the far model drives pin and code; APB master lives here.
module adc_sequencing_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import asc_pkg::*;
   localparam logic [11:0] A_CTRL = {CTRL_IDX[9:0], 2'b00};
   localparam logic [11:0] A_CFG  = {CFG_IDX[9:0], 2'b00};
   localparam logic [11:0] A_THD  = {THIRD_IDX[9:0], 2'b00};
   localparam logic [11:0] A_RES  = {RESULT_IDX[9:0], 2'b00};
   logic pclk = 0, presetn = 0, fall_req = 0, ext_pin, ref_on, sh_on;
   logic busy, cstart, irq, e;
   logic [9:0] conv_code, code_drv = 10'h0;
   logic [31:0] q;
   asc_apb_req_s req = '0;
   asc_apb_rsp_s rsp;
   asc_sel_s sel;
   int fail_count = 0, n_checks = 0, seed = 32'h84a75407;
   int n_start = 0, n_irq = 0, cyc = 0, gap = 0, s0, i0, k;
   always #20 pclk = ~pclk;
   asc_top dut_u (.pclk(pclk), .presetn(presetn), .apb_req(req),
      .apb_rsp(rsp), .external_trigger_pin(ext_pin),
      .conv_code(conv_code), .analog_sel(sel), .reference_connect(ref_on),
      .sample_hold_on(sh_on), .convert_busy(busy), .conv_start(cstart),
      .conv_irq(irq));
   asc_far_model far_u (.pclk(pclk), .presetn(presetn), .fall_req(fall_req),
      .busy(busy), .code(code_drv), .external_trigger_pin(ext_pin),
      .conv_code(conv_code));
   // gap counts cycles from a start pulse to its completion pulse
   always @(posedge pclk) begin
      cyc <= cstart ? 0 : cyc + 1;
      if (cstart) n_start <= n_start + 1;
      if (irq) n_irq <= n_irq + 1;
      if (irq) gap <= cyc + 1;
   end
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one APB transfer; holds the request until pready is sampled
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge pclk);
      req.penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      q = rsp.prdata;
      e = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      if (n >= 20) chk("pready", 1, 0);
   endtask
   function logic [31:0] ctl(input logic [2:0] c, input logic m, t, s);
      return {24'h0, 1'b0, s, t, 1'b0, m, c};
   endfunction
   function logic [31:0] cfg(input logic r, f, input logic [1:0] x);
      return {24'h0, x, f, 1'b0, r, 3'h0};
   endfunction
   function int len(input logic sh, r);
      return sh ? (r ? CYC_SH_10 : CYC_SH_8) : (r ? CYC_NSH_10 : CYC_NSH_8);
   endfunction
   task wait_irq();
      k = 0;
      while (n_irq == i0 && k < 200) begin
         @(posedge pclk);
         k++;
      end
      if (k >= 200) chk("irq wait", 1, 0);
      @(posedge pclk);
   endtask
   task summarize();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #(40 * 8000);
      fail_count++;
      summarize();
   end
   initial begin
      logic [2:0] ch;
      logic [1:0] x, g;
      logic r, sh;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, A_CTRL, 0);
      chk("ctrl reset", 0, q);
      apb(0, A_CFG, 0);
      chk("cfg reset", 0, q);
      apb(0, 12'h004, 0);
      chk("unmapped err", 1, e);
      apb(1, A_CTRL, ctl(0, 0, 0, 1));
      repeat (80) @(posedge pclk);
      chk("start w/o ref", 0, n_start);
      $display("test reset_refusals done");
      for (int i = 0; i < 6; i++) begin
         ch = $random(seed);
         g = $random(seed);
         x = i % 3;
         r = (i == 2 || i == 3 || i == 5);
         sh = (i % 4 == 1 || i == 4);
         apb(1, A_THD, {29'h0, g, sh});
         apb(1, A_CFG, cfg(r, 1, x));
         repeat (26) @(posedge pclk);
         code_drv <= $random(seed);
         i0 = n_irq;
         apb(1, A_CTRL, ctl(ch, 0, 0, 1));
         @(negedge pclk); // let the landed write settle
         chk("channel", ch, sel.channel);
         chk("ext sel", x, sel.ext);
         chk("group", g, sel.group);
         chk("sh out", sh, sh_on);
         wait_irq();
         chk("conv len", len(sh, r) + 1, gap);
         apb(0, A_RES + 4 * (x == 1 ? 0 : x == 2 ? 1 : ch), 0);
         chk("result", code_drv & (r ? 10'h3FF : 10'h0FF), q);
         apb(0, A_CTRL, 0);
         chk("start cleared", 0, q[CTRL_START]);
      end
      apb(1, A_CFG, cfg(0, 1, 3));
      apb(0, A_CFG, 0);
      chk("ext bad", 0, q[CFG_EXT_LSB +: 2]);
      chk("ref out", 1, ref_on);
      $display("test one_shot done");
      s0 = n_start;
      i0 = n_irq;
      apb(1, A_CTRL, ctl(5, 1, 0, 0));
      apb(1, A_CTRL, ctl(5, 1, 0, 0));
      apb(1, A_CTRL, ctl(5, 1, 0, 1));
      repeat (130) @(posedge pclk);
      apb(1, A_CFG, cfg(0, 0, 0));
      apb(0, A_CFG, 0);
      chk("ref kept", 1, q[CFG_REF]);
      chk("ref pin kept", 1, ref_on);
      chk("repeat starts", 1, n_start - s0 >= 4);
      apb(1, A_CTRL, ctl(5, 1, 0, 0));
      repeat (2) @(posedge pclk);
      chk("halted", 0, busy);
      chk("repeat irq", i0, n_irq);
      $display("test repeat done");
      apb(1, A_CTRL, ctl(2, 0, 1, 0));
      s0 = n_start;
      fall_req <= 1'b1;
      @(posedge pclk);
      fall_req <= 1'b0;
      apb(1, A_CTRL, ctl(2, 0, 1, 1));
      repeat (10) @(posedge pclk);
      chk("unarmed fall", s0, n_start);
      i0 = n_irq;
      fall_req <= 1'b1;
      @(posedge pclk);
      fall_req <= 1'b0;
      wait_irq();
      chk("ext start", s0 + 1, n_start);
      chk("ext irq", i0 + 1, n_irq);
      apb(1, A_CFG, cfg(0, 0, 0));
      @(negedge pclk);
      chk("ref cut", 0, ref_on);
      $display("test ext_trigger done");
      summarize();
   end
endmodule
